// ### verilog/rsm_top.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RQ1) bit 7 switches supply monitor on/off
// (RQ2) supply reset needs enable and source select
// (RQ3) software waits before selecting supply source
// (RQ4) bit 6 reads supply above threshold
// (RQ5) bit 5 picks high trip, resets 0
// (RQ6) flash-writing software uses high trip level
// (RQ7) control bits 4:0 read zero, ignore writes
// (RQ8) low reset pin resets the device
// (RQ9) pin reset sets cause bit 0
// (RQ10) clock-loss one-shot times out into reset
// (RQ11) cause bit 2 marks clock-loss reset only
// (RQ12) cause bit 2 write enables clock-loss detector
// (RQ13) clock-loss, comparator resets leave pin undriven
// (RQ14) cause bit 5 write enables comparator reset
// (RQ15) software settles comparator before enabling reset
// (RQ16) comparator low holds device in reset
// (RQ17) cause bit 5 marks comparator reset only
// (RQ18) power-on sets bit 1, clears others
// (RQ19) cause bit 1 write selects supply source
// (RQ20) cause bit 4 write forces reset, flags it
// (RQ21) power-on, supply resets drive pin low
// (RQ22) all requests merge into one reset, flags kept
module rsm_top #(
  parameter int MIN_HOLD_CYCLES = rsm_pkg::RST_MIN_HOLD_CYCLES,
  parameter int MCD_CYCLES      = rsm_pkg::MCD_TIMEOUT_CYCLES
) (
  // clock and power-on reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // register port
  input  wire logic [rsm_pkg::AW-1:0] addr_i,
  input  wire logic [rsm_pkg::DW-1:0] wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [rsm_pkg::DW-1:0] rdata_o,
  // external reset pin, open drain
  input  wire logic                 rst_pin_i,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe_n_o,
  // analog sources, asynchronous
  input  wire logic                 supply_above_i,
  input  wire logic                 comparator_i,
  input  wire logic                 mon_clk_i,
  // controls to analog and system
  output logic                      supply_monitor_enable_o,
  output logic                      monitor_threshold_select_o,
  output logic                      sys_rst_o
);
  import rsm_pkg::*;

  localparam int HW = $clog2(MIN_HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(MIN_HOLD_CYCLES);
  localparam int BW = $clog2(PIN_BLANK_CYCLES + 1);
  localparam logic [BW-1:0] BLANK_LOAD = BW'(PIN_BLANK_CYCLES);

  // address decode shared by read and write paths
  function automatic logic f_hit(input logic [AW-1:0] a, input logic [AW-1:0] target);
    return a == target;
  endfunction

  // synchronised pin and analog levels
  logic [2:0] async_raw;
  logic [2:0] async_sync;
  logic       pin_high;
  logic       supply_above;
  logic       cmp_high;

  // state
  rsm_state_t       state;
  rsm_state_t       next_state;
  logic [HW-1:0]    hold_cnt;
  logic [BW-1:0]    blank_cnt;
  logic             drive_pin;

  // control bits
  logic             supply_monitor_enable;
  logic             monitor_threshold_select;
  logic             supply_source_select;
  logic             clock_loss_enable;
  logic             comparator_reset_enable;

  // cause flags
  logic             pin_reset_flag;
  logic             power_on_reset_flag;
  logic             clock_loss_enable_flag;
  logic             software_reset_flag;
  logic             comparator_reset_enable_flag;

  // requests
  logic             pin_req;
  logic             supply_req;
  logic             cmp_req;
  logic             clk_req;
  logic             sw_req;
  logic             any_req;
  logic             level_req;
  logic             entering;
  logic             leaving;
  logic             wr_smc;
  logic             wr_rcr;
  logic [DW-1:0]    next_rdata;

  rsm_if mon_bus ();

  assign async_raw = {comparator_i, supply_above_i, rst_pin_i};

  // idle levels: pin released, supply good, comparator high
  rsm_sync #(.W(3), .RST_VAL(3'h7)) u_in_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (async_raw),
    .q_o    (async_sync)
  );

  assign pin_high     = async_sync[0];
  assign supply_above = async_sync[1];
  assign cmp_high     = async_sync[2];

  rsm_clk_mon #(.TIMEOUT_CYCLES(MCD_CYCLES)) u_clk_mon (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .mon_clk_i (mon_clk_i),
    .ctl       (mon_bus.mon)
  );

  // (RQ12) detector runs only while enabled
  assign mon_bus.enable = clock_loss_enable;

  // writes are ignored while the system is held in reset
  assign wr_smc = wr_i && f_hit(addr_i, SMC_ADDR) && (state == RSM_RUN);
  assign wr_rcr = wr_i && f_hit(addr_i, RCR_ADDR) && (state == RSM_RUN);

  // (RQ8) low pin; own drive and release are blanked
  assign pin_req    = !pin_high && !drive_pin && (blank_cnt == '0);
  // (RQ2) needs both enable and source select
  assign supply_req = supply_monitor_enable && supply_source_select && !supply_above;
  // (RQ16) comparator low is a level request
  assign cmp_req    = comparator_reset_enable && !cmp_high;
  // (RQ10) timeout from the one-shot
  assign clk_req    = clock_loss_enable && mon_bus.timeout;
  // (RQ20) write of one forces reset
  assign sw_req     = wr_rcr && wdata_i[RCR_SW_BIT];

  // (RQ22) one merged reset request
  assign any_req    = pin_req || supply_req || cmp_req || clk_req || sw_req;
  assign level_req  = pin_req || supply_req || cmp_req || clk_req;

  assign entering = (state == RSM_RUN) && any_req;
  assign leaving  = (state == RSM_RESET) && (hold_cnt == '0) && !level_req;

  always_comb begin
    next_state = state;
    case (state)
      RSM_RUN: begin
        if (any_req) begin
          next_state = RSM_RESET;
        end
      end
      RSM_RESET: begin
        if (leaving) begin
          next_state = RSM_RUN;
        end
      end
      default: begin
        next_state = RSM_RESET;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= RSM_RESET;
    end else begin
      state <= next_state;
    end
  end

  // least hold, reloaded at every entry
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_cnt <= HOLD_LOAD;
    end else if (entering) begin
      hold_cnt <= HOLD_LOAD;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - HW'(1);
    end
  end

  // (RQ22) reset stands from entry to release
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sys_rst_o <= 1'b1;
    end else begin
      sys_rst_o <= (next_state == RSM_RESET);
    end
  end

  // pin drive, only by sources that own the pin
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // (RQ21) power-on drives the pin low
      drive_pin <= 1'b1;
    end else if (entering) begin
      // (RQ21) supply reset drives the pin
      // (RQ13) other sources leave it undriven
      drive_pin <= supply_req;
    end else if (leaving) begin
      drive_pin <= 1'b0;
    end
  end

  // blanking after own release: pull-up rise is slow
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      blank_cnt <= '0;
    end else if (leaving && drive_pin) begin
      blank_cnt <= BLANK_LOAD;
    end else if (blank_cnt != '0) begin
      blank_cnt <= blank_cnt - BW'(1);
    end
  end

  // open drain: only ever pulls low
  assign rst_pin_o      = 1'b0;
  assign rst_pin_oe_n_o = !drive_pin;

  // (RQ1) monitor on/off, kept over non-power resets
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      supply_monitor_enable <= SMC_ENABLE_POR;
    end else if (wr_smc) begin
      supply_monitor_enable <= wdata_i[SMC_ENABLE_BIT];
    end
  end

  // (RQ5) trip level, low again on any reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      monitor_threshold_select <= SMC_THRESHOLD_RST;
    end else if (leaving) begin
      monitor_threshold_select <= SMC_THRESHOLD_RST;
    end else if (wr_smc) begin
      monitor_threshold_select <= wdata_i[SMC_THRESHOLD_BIT];
    end
  end

  assign supply_monitor_enable_o    = supply_monitor_enable;
  assign monitor_threshold_select_o = monitor_threshold_select;

  // (RQ19) supply source select survives non-power resets
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      supply_source_select <= 1'b1;
    end else if (leaving) begin
      if (power_on_reset_flag) begin
        supply_source_select <= 1'b1;
      end
    end else if (wr_rcr) begin
      supply_source_select <= wdata_i[RCR_POR_BIT];
    end
  end

  // (RQ12) clock-loss detector on/off
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clock_loss_enable <= 1'b0;
    end else if (leaving) begin
      clock_loss_enable <= 1'b0;
    end else if (wr_rcr) begin
      clock_loss_enable <= wdata_i[RCR_CLK_BIT];
    end
  end

  // (RQ14) comparator as reset source
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      comparator_reset_enable <= 1'b0;
    end else if (leaving) begin
      comparator_reset_enable <= 1'b0;
    end else if (wr_rcr) begin
      comparator_reset_enable <= wdata_i[RCR_CMP_BIT];
    end
  end

  // cause flags, loaded whole at entry so stale causes read 0
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // (RQ18) power-on flag alone
      pin_reset_flag               <= 1'b0;
      power_on_reset_flag          <= 1'b1;
      clock_loss_enable_flag       <= 1'b0;
      software_reset_flag          <= 1'b0;
      comparator_reset_enable_flag <= 1'b0;
    end else if (entering) begin
      // (RQ9) pin cause
      pin_reset_flag               <= pin_req;
      // (RQ18) supply reset also reads as power-on
      power_on_reset_flag          <= supply_req;
      // (RQ11) clock-loss cause only
      clock_loss_enable_flag       <= clk_req;
      // (RQ20) software cause
      software_reset_flag          <= sw_req;
      // (RQ17) comparator cause only
      comparator_reset_enable_flag <= cmp_req;
    end
  end

  // read word, zero unless a read strobe hits
  always_comb begin
    next_rdata = ZERO_BYTE;
    if (rd_i) begin
      if (f_hit(addr_i, SMC_ADDR)) begin
        next_rdata[SMC_ENABLE_BIT]    = supply_monitor_enable;
        // (RQ4) live monitor output
        next_rdata[SMC_STATUS_BIT]    = supply_above;
        next_rdata[SMC_THRESHOLD_BIT] = monitor_threshold_select;
        // (RQ7) low bits stay zero
      end else if (f_hit(addr_i, RCR_ADDR)) begin
        next_rdata[RCR_PIN_BIT] = pin_reset_flag;
        next_rdata[RCR_POR_BIT] = power_on_reset_flag;
        next_rdata[RCR_CLK_BIT] = clock_loss_enable_flag;
        next_rdata[RCR_SW_BIT]  = software_reset_flag;
        next_rdata[RCR_CMP_BIT] = comparator_reset_enable_flag;
      end
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= ZERO_BYTE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : rsm_top
`default_nettype wire

// ### verilog/rsm_pkg.sv
`default_nettype none
package rsm_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 4;

  // cycles from a least time, rounded up, never below one
  function automatic int rsm_cycles_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // clock-loss one-shot timeout and least time in reset
  localparam int MCD_TIMEOUT_NS      = 1000;
  localparam int MCD_TIMEOUT_CYCLES  = rsm_cycles_up(MCD_TIMEOUT_NS);
  localparam int RST_MIN_HOLD_NS     = 100;
  localparam int RST_MIN_HOLD_CYCLES = rsm_cycles_up(RST_MIN_HOLD_NS);
  // pin ignored after release: two sync stages plus pull-up rise
  localparam int PIN_BLANK_CYCLES    = 4;

  // register bus
  localparam int AW = 8;
  localparam int DW = 8;
  localparam logic [AW-1:0] SMC_ADDR = 8'hff;
  localparam logic [AW-1:0] RCR_ADDR = 8'hef;

  // supply_monitor_control fields
  localparam int SMC_ENABLE_BIT    = 7;
  localparam int SMC_STATUS_BIT    = 6;
  localparam int SMC_THRESHOLD_BIT = 5;
  localparam logic SMC_THRESHOLD_RST = 1'b0;
  localparam logic SMC_ENABLE_POR    = 1'b1;

  // reset_cause_register fields
  localparam int RCR_PIN_BIT   = 0;
  localparam int RCR_POR_BIT   = 1;
  localparam int RCR_CLK_BIT   = 2;
  localparam int RCR_SW_BIT    = 4;
  localparam int RCR_CMP_BIT   = 5;

  localparam logic [DW-1:0] ZERO_BYTE = 8'h00;

  // reset sequencer states
  typedef enum logic [0:0] {
    RSM_RUN   = 1'b0,
    RSM_RESET = 1'b1
  } rsm_state_t;

endpackage : rsm_pkg
`default_nettype wire

// ### verilog/rsm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rsm_if;
  logic enable;
  logic timeout;
  modport ctl (output enable, input timeout);
  modport mon (input enable, output timeout);
endinterface : rsm_if
`default_nettype wire

// ### verilog/rsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsm_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // async level in, synchronised level out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage1 <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule : rsm_sync
`default_nettype wire

// ### verilog/rsm_clk_mon.sv
`timescale 1ns/1ps
`default_nettype none
module rsm_clk_mon #(
  parameter int TIMEOUT_CYCLES = rsm_pkg::MCD_TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // monitored clock, asynchronous
  input  wire logic mon_clk_i,
  // enable in, timeout out
  rsm_if.mon        ctl
);
  import rsm_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);

  logic          mon_sync;
  logic          mon_prev;
  logic [CW-1:0] quiet_cnt;

  rsm_sync #(.W(1), .RST_VAL(1'b0)) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (mon_clk_i),
    .q_o    (mon_sync)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mon_prev <= 1'b0;
    end else begin
      mon_prev <= mon_sync;
    end
  end

  // (RQ10) one-shot retriggered by edges
  always_ff @(posedge clk_i) begin
    if (srst_i || !ctl.enable || (mon_sync != mon_prev)) begin
      quiet_cnt   <= '0;
      ctl.timeout <= 1'b0;
    end else if (quiet_cnt == LIMIT) begin
      ctl.timeout <= 1'b1;
    end else begin
      quiet_cnt <= quiet_cnt + CW'(1);
    end
  end
endmodule : rsm_clk_mon
`default_nettype wire

// ### test/rsm_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rsm_top_monitor
  import rsm_pkg::*;
#(
  parameter int MIN_HOLD_CYCLES = 25,
  parameter int MCD_CYCLES      = 250
) (
  // clock and reset
  input wire logic          clk_i,
  input wire logic          srst_i,
  // register port
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  // pin and sources
  input wire logic          rst_pin_i,
  input wire logic          rst_pin_oe_n_o,
  input wire logic          supply_above_i,
  input wire logic          comparator_i,
  // controls
  input wire logic          supply_monitor_enable_o,
  input wire logic          monitor_threshold_select_o,
  input wire logic          sys_rst_o
);
  logic          cmp_en;
  logic          rst_q;
  logic [DW-1:0] wd_q;
  int            hold_cnt;

  // shadow of comparator enable; write wins over the exit clear
  always_ff @(posedge clk_i) begin
    if (srst_i)
      cmp_en <= 1'b0;
    else if (wr_i && addr_i == RCR_ADDR && !sys_rst_o)
      cmp_en <= wdata_i[RCR_CMP_BIT];
    else if (rst_q && !sys_rst_o)
      cmp_en <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    rst_q    <= sys_rst_o;
    wd_q     <= wdata_i;
    hold_cnt <= sys_rst_o ? hold_cnt + 1 : 0;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence smc_wr_s;
    wr_i && addr_i == SMC_ADDR && !sys_rst_o;
  endsequence
  sequence sw_wr_s;
    wr_i && addr_i == RCR_ADDR && wdata_i[RCR_SW_BIT] && !sys_rst_o;
  endsequence
  sequence pin_low_s;
    (!rst_pin_i && rst_pin_oe_n_o)[*6];
  endsequence
  sequence cmp_low_s;
    (cmp_en && !comparator_i)[*3];
  endsequence

  a_low_bits_zero: assert property ($past(rd_i) && $past(addr_i) == SMC_ADDR |-> rdata_o[4:0] == 5'h0)
    else $error("control low bits not zero");
  a_enable_readback: assert property ($past(rd_i) && $past(addr_i) == SMC_ADDR |->
    rdata_o[SMC_ENABLE_BIT] == $past(supply_monitor_enable_o)) else $error("enable readback wrong");
  a_thr_readback: assert property ($past(rd_i) && $past(addr_i) == SMC_ADDR |->
    rdata_o[SMC_THRESHOLD_BIT] == $past(monitor_threshold_select_o)) else $error("threshold readback wrong");
  a_enable_write: assert property (smc_wr_s |=> supply_monitor_enable_o == wd_q[SMC_ENABLE_BIT])
    else $error("enable write lost");
  a_thr_write: assert property (smc_wr_s ##1 !sys_rst_o |->
    monitor_threshold_select_o == wd_q[SMC_THRESHOLD_BIT]) else $error("threshold write lost");
  a_sw_entry: assert property (sw_wr_s |=> sys_rst_o)
    else $error("software reset not entered");
  a_hold_min: assert property ($fell(sys_rst_o) |-> hold_cnt >= MIN_HOLD_CYCLES + 1)
    else $error("reset released too early");
  a_pin_entry: assert property (pin_low_s |-> ##[0:3] sys_rst_o)
    else $error("pin low gave no reset");
  a_cmp_entry: assert property (cmp_low_s |-> ##[0:3] sys_rst_o)
    else $error("comparator low gave no reset");
  a_pin_undriven: assert property ($rose(sys_rst_o) && $past(supply_above_i, 3) |->
    rst_pin_oe_n_o[*4]) else $error("pin driven by foreign reset");
  a_drive_in_reset: assert property (!rst_pin_oe_n_o |-> sys_rst_o)
    else $error("pin driven outside reset");
endmodule // rsm_top_monitor

bind rsm_top rsm_top_monitor #(.MIN_HOLD_CYCLES(MIN_HOLD_CYCLES), .MCD_CYCLES(MCD_CYCLES)) mon_u (
  .clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rst_pin_i, .rst_pin_oe_n_o,
  .supply_above_i, .comparator_i, .supply_monitor_enable_o, .monitor_threshold_select_o, .sys_rst_o);
`default_nettype wire

// ### test/rsm_board.sv
`timescale 1ns/1ps
`default_nettype none
module rsm_board #(
  parameter int LOW_TRIP_MV  = 1700,
  parameter int HIGH_TRIP_MV = 2400
) (
  // device side
  input  wire logic rst_pin_oe_n_i,
  input  wire logic rst_pin_drv_i,
  input  wire logic monitor_on_i,
  input  wire logic high_trip_i,
  // analog scene
  input  wire logic ext_low_i,
  input  wire logic clk_stop_i,
  input  wire integer vdd_mv_i,
  input  wire integer cmp_plus_mv_i,
  input  wire integer cmp_minus_mv_i,
  // to device
  output logic      rst_pin_o,
  output logic      supply_above_o,
  output logic      comparator_o,
  output logic      mon_clk_o
);
  assign rst_pin_o = !(ext_low_i || (!rst_pin_oe_n_i && !rst_pin_drv_i));
  // above trip reads 1; an off monitor reads high
  assign supply_above_o = !monitor_on_i || vdd_mv_i > (high_trip_i ? HIGH_TRIP_MV : LOW_TRIP_MV);
  assign comparator_o = cmp_plus_mv_i >= cmp_minus_mv_i;
  // system clock stands still when lost
  initial begin
    mon_clk_o = 1'b0;
    forever #6 if (!clk_stop_i) mon_clk_o = ~mon_clk_o;
  end
endmodule // rsm_board
`default_nettype wire

// ### test/rsm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rsm_top_tb;
  import rsm_pkg::*;
  localparam int MINH = 4;
  localparam int MCDC = 8;
  typedef struct {logic w; logic [AW-1:0] a; logic [DW-1:0] d; logic [DW-1:0] e;} rsm_row_t;
  logic          clk_i = 1'b0;
  logic          srst_i = 1'b1;
  logic [AW-1:0] addr_i = 8'h00;
  logic [DW-1:0] wdata_i = 8'h00;
  logic          wr_i = 1'b0;
  logic          rd_i = 1'b0;
  logic [DW-1:0] rdata_o;
  logic          rst_pin_i, rst_pin_o, rst_pin_oe_n_o, supply_above_i, comparator_i, mon_clk_i;
  logic          supply_monitor_enable_o, monitor_threshold_select_o, sys_rst_o;
  logic          ext_low = 1'b0;
  logic          clk_stop = 1'b0;
  int            vdd_mv = 3300;
  int            cp_plus = 1000;
  int            cp_minus = 500;
  int            err_total = 0;
  int            checks_done = 0;
  rsm_row_t      rows [10] = '{
    '{1'b0, SMC_ADDR, 8'h00, 8'hc0}, '{1'b1, SMC_ADDR, 8'hff, 8'h00}, '{1'b0, SMC_ADDR, 8'h00, 8'he0},
    '{1'b1, SMC_ADDR, 8'h1f, 8'h00}, '{1'b0, SMC_ADDR, 8'h00, 8'h40}, '{1'b1, SMC_ADDR, 8'h80, 8'h00},
    '{1'b0, SMC_ADDR, 8'h00, 8'hc0}, '{1'b0, RCR_ADDR, 8'h00, 8'h02}, '{1'b1, 8'h33, 8'hff, 8'h00},
    '{1'b0, 8'h33, 8'h00, 8'h00}};

  always #2 clk_i = ~clk_i;

  rsm_top #(.MIN_HOLD_CYCLES(MINH), .MCD_CYCLES(MCDC)) dut_u (
    .clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rst_pin_i, .rst_pin_o, .rst_pin_oe_n_o,
    .supply_above_i, .comparator_i, .mon_clk_i, .supply_monitor_enable_o, .monitor_threshold_select_o,
    .sys_rst_o);

  rsm_board board_u (
    .rst_pin_oe_n_i(rst_pin_oe_n_o), .rst_pin_drv_i(rst_pin_o), .monitor_on_i(supply_monitor_enable_o),
    .high_trip_i(monitor_threshold_select_o), .ext_low_i(ext_low), .clk_stop_i(clk_stop),
    .vdd_mv_i(vdd_mv), .cmp_plus_mv_i(cp_plus), .cmp_minus_mv_i(cp_minus), .rst_pin_o(rst_pin_i),
    .supply_above_o(supply_above_i), .comparator_o(comparator_i), .mon_clk_o(mon_clk_i));

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // answer sampled mid-cycle, strobe dropped before the next one
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [DW-1:0] e);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(negedge clk_i);
    if (!w)
      chk("read data", e, rdata_o);
    @(posedge clk_i);
  endtask

  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (sys_rst_o !== lvl && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk("system reset", {7'h0, lvl}, {7'h0, sys_rst_o});
    @(posedge clk_i);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(4 * 3000);
    err_total++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    wait_rst(1'b0, 80);
    foreach (rows[i]) bus(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
    $display("register rows done");
    bus(1'b1, SMC_ADDR, 8'ha0, 8'h00);
    bus(1'b1, RCR_ADDR, 8'h12, 8'h00);
    wait_rst(1'b0, 60);
    bus(1'b0, RCR_ADDR, 8'h00, 8'h10);
    bus(1'b0, SMC_ADDR, 8'h00, 8'hc0);
    $display("software reset done");
    bus(1'b1, RCR_ADDR, 8'h06, 8'h00);
    repeat (20) @(posedge clk_i);
    chk("running clock", 8'h00, {7'h0, sys_rst_o});
    clk_stop <= 1'b1;
    wait_rst(1'b1, 40);
    clk_stop <= 1'b0;
    wait_rst(1'b0, 60);
    bus(1'b0, RCR_ADDR, 8'h00, 8'h04);
    $display("clock loss done");
    bus(1'b1, RCR_ADDR, 8'h22, 8'h00);
    cp_plus <= 200;
    wait_rst(1'b1, 20);
    cp_plus <= 1000;
    wait_rst(1'b0, 60);
    bus(1'b0, RCR_ADDR, 8'h00, 8'h20);
    $display("comparator done");
    ext_low <= 1'b1;
    wait_rst(1'b1, 20);
    repeat (5) @(posedge clk_i);
    ext_low <= 1'b0;
    wait_rst(1'b0, 60);
    bus(1'b0, RCR_ADDR, 8'h00, 8'h01);
    $display("pin reset done");
    bus(1'b1, RCR_ADDR, 8'h00, 8'h00);
    vdd_mv <= 1000;
    repeat (10) @(posedge clk_i);
    chk("unselected supply", 8'h00, {7'h0, sys_rst_o});
    bus(1'b1, RCR_ADDR, 8'h02, 8'h00);
    wait_rst(1'b1, 20);
    repeat (2) @(posedge clk_i);
    chk("pin drive", 8'h00, {7'h0, rst_pin_oe_n_o});
    chk("pin data", 8'h00, {7'h0, rst_pin_o});
    vdd_mv <= 3300;
    wait_rst(1'b0, 60);
    bus(1'b0, RCR_ADDR, 8'h00, 8'h02);
    $display("supply reset done");
    bus(1'b1, SMC_ADDR, 8'h20, 8'h00);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    wait_rst(1'b0, 80);
    bus(1'b0, SMC_ADDR, 8'h00, 8'hc0);
    bus(1'b0, RCR_ADDR, 8'h00, 8'h02);
    $display("power-on reset done");
    give_verdict;
  end
endmodule // rsm_top_tb
`default_nettype wire
